/* File: verif/isp_programmer.sv */
// programmer model: drives the link pins and captures each reply
// assumes the bench clock; every pin change lands on its falling edge
`timescale 1ns/100ps
module isp_programmer (
   // bench clock
   input wire logic core_clk,
   // link pins
   input wire logic sdo,
   output logic sclk,
   output logic sdi,
   output logic progResetN,
   // reply
   output logic [31:0] rxWord,
   output logic rxValid
);
   // ----
   // link idle state
   // ----
   initial
   begin
      sclk = 1'b0;
      sdi = 1'b0;
      progResetN = 1'b1;
      rxWord = 32'h0;
      rxValid = 1'b0;
   end
   // open or close a session; the power-up wait is scaled down
   task automatic session(input logic on);
      begin
         progResetN = !on;
         repeat (40) @(negedge core_clk);
      end
   endtask
   // one instruction, msb first; clock runs only inside it
   task automatic frame(input logic [31:0] w);
      integer i;
      begin
         for (i = 31; i >= 0; i = i - 1)
         begin
            sdi = w[i];
            repeat (4) @(negedge core_clk);
            sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            rxWord[i] = sdo; // read late in high phase, past the sync delay
            sclk = 1'b0;
         end
         sdi = !sdi; // no stale data between frames
         rxValid = 1'b1;
         @(negedge core_clk);
         rxValid = 1'b0;
      end
   endtask
endmodule

/* File: verif/serial_prog_port_sva.sv */
// checker for the serial programming port
// assumes only the port pins; bound onto every instance
`timescale 1ns/100ps
module serial_prog_port_sva (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   input wire clkEn,
   // link pins
   input wire sclk,
   input wire sdi,
   input wire progResetN,
   input wire sdo,
   // status
   input wire progEnabled,
   input wire opPending
);
   // ----
   // edge age counters
   // ----
   logic sclkQ;
   logic [3:0] sinceFall;
   logic [3:0] sinceRise;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // saturate so a long idle never wraps back into a window
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclkQ <= 1'b0;
         sinceFall <= 4'hf;
         sinceRise <= 4'hf;
      end
      else
      begin
         sclkQ <= sclk;
         sinceFall <= (sclkQ && !sclk) ? 4'h0 : sinceFall + {3'h0, sinceFall != 4'hf};
         sinceRise <= (!sclkQ && sclk) ? 4'h0 : sinceRise + {3'h0, sinceRise != 4'hf};
      end
   end
   // ----
   // properties
   // ----
   sequence s_high_run;
      (!progResetN && sclk) [*4];
   endsequence
   AST_IDLE_OUTSIDE_SESSION: assert property (progResetN [*8] |-> !sdo && !progEnabled)
      else $error("sdo or enable active outside a session");
   AST_ENABLE_IN_SESSION: assert property ($rose(progEnabled) |-> !progResetN && $past(!progResetN, 4))
      else $error("enable set outside a session");
   AST_COMMIT_NEEDS_ENABLE: assert property ($rose(opPending) |-> progEnabled && !progResetN)
      else $error("operation started without enable");
   AST_SDO_AFTER_FALL: assert property (!progResetN && $changed(sdo) |-> sinceFall inside {[2:7]})
      else $error("sdo moved away from a clock fall");
   AST_SDO_STEADY_HIGH: assert property (s_high_run |-> $stable(sdo))
      else $error("sdo moved during clock high phase");
   AST_PENDING_AFTER_RISE: assert property ($rose(opPending) |-> sinceRise inside {[3:8]})
      else $error("busy rose away from the last clock rise");
   AST_PENDING_HOLDS: assert property ($rose(opPending) |-> opPending [*8])
      else $error("busy dropped too early");
   AST_ENABLE_DROPS_ON_EXIT: assert property ($fell(progEnabled) |-> progResetN && $past(progResetN, 2))
      else $error("enable dropped inside a session");
endmodule
bind serial_prog_port serial_prog_port_sva i_serial_prog_port_sva (.core_clk(core_clk), .resetn(resetn),
   .clkEn(clkEn), .sclk(sclk), .sdi(sdi), .progResetN(progResetN), .sdo(sdo),
   .progEnabled(progEnabled), .opPending(opPending));

/* File: verif/tb_serial_prog_port.sv */
// self-checking bench for the serial programming port
// assumes the programmer model and the bound checker are compiled first
`timescale 1ns/100ps
module tb_serial_prog_port;
   logic core_clk, resetn, clkEn, sclk, sdi, progResetN, sdo, progEnabled, opPending, rxValid;
   logic [31:0] rxWord, r, e;
   logic [31:0] expQ[$];
   logic [12:0] fa;
   logic [9:0] ea;
   logic [7:0] d0, d1, d2, d3;
   integer n_errors, samples_checked;
   integer cycles = 0;
   // short commit waits keep the run brief
   serial_prog_port #(.FLASH_WAIT(21'h14), .EE_WAIT(21'h14), .ERASE_WAIT(21'h14)) i_serial_prog_port (
      .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .sclk(sclk), .sdi(sdi),
      .progResetN(progResetN), .sdo(sdo), .progEnabled(progEnabled), .opPending(opPending));
   isp_programmer i_isp_programmer (.core_clk(core_clk), .sdo(sdo), .sclk(sclk), .sdi(sdi),
      .progResetN(progResetN), .rxWord(rxWord), .rxValid(rxValid));
   // ----
   // clock, timeout, reply monitor
   // ----
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // cut a hang short; ceiling well above the expected run
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         n_errors = n_errors + 1;
         summarize();
      end
   end
   // byte one of a reply echoes the previous frame, so it is masked
   always @(posedge rxValid)
   begin
      e = expQ.pop_front();
      samples_checked = samples_checked + 1;
      if ((rxWord & 32'h00ffffff) !== e)
      begin
         $display("[FAIL] reply expected %h seen %h", e, rxWord & 32'h00ffffff);
         n_errors = n_errors + 1;
      end
   end
   // ----
   // tasks
   // ----
   task automatic xfer(input logic [31:0] w, input logic [7:0] b4, input logic use4);
      begin
         expQ.push_back({8'h00, w[31:16], use4 ? b4 : w[15:8]});
         i_isp_programmer.frame(w);
      end
   endtask
   task automatic rdE(input logic [9:0] a, input logic [7:0] x);
      xfer({8'ha0, 6'h00, a, 8'h00}, x, 1'b1);
   endtask
   task automatic rdF(input logic hi, input logic [12:0] a, input logic [7:0] x);
      xfer({4'h2, hi, 6'h00, a, 8'h00}, x, 1'b1);
   endtask
   task automatic ld(input logic [7:0] op, input logic [5:0] a, input logic [7:0] d);
      xfer({op, 8'h00, 2'h0, a, d}, 8'h00, 1'b0);
   endtask
   task automatic waitIdle();
      integer k;
      begin
         repeat (4) @(negedge core_clk);
         for (k = 0; opPending !== 1'b0 && k < 20000; k = k + 1)
            @(negedge core_clk);
         if (opPending !== 1'b0)
         begin
            $display("[FAIL] opPending expected 0 seen %b", opPending);
            n_errors = n_errors + 1;
         end
      end
   endtask
   task automatic summarize();
      begin
         $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // ----
   // main sequence
   // ----
   initial
   begin
      resetn = 1'b0;
      clkEn = 1'b1;
      n_errors = 0;
      samples_checked = 0;
      r = $urandom(23);
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      r = $urandom;
      fa = r[12:0];
      ea = r[25:16];
      r = $urandom;
      {d0, d1, d2, d3} = r;
      i_isp_programmer.session(1'b1);
      xfer(32'hac530000, 8'h00, 1'b0);
      xfer(32'hac800000, 8'h00, 1'b0);
      xfer(32'hf0000000, 8'h01, 1'b1);
      waitIdle();
      xfer(32'hf0000000, 8'h00, 1'b1);
      rdF(1'b1, fa, 8'hff);
      rdE(ea, 8'hff);
      // a fresh session refuses writes until enable is seen again
      i_isp_programmer.session(1'b0);
      i_isp_programmer.session(1'b1);
      xfer({8'hc0, 6'h00, ea, d0}, 8'h00, 1'b0);
      waitIdle();
      rdE(ea, 8'hff);
      xfer(32'hac530000, 8'h00, 1'b0);
      // a second write to one byte must not merge with the first
      xfer({8'hc0, 6'h00, ea, d0}, 8'h00, 1'b0);
      waitIdle();
      xfer({8'hc0, 6'h00, ea, ~d0}, 8'h00, 1'b0);
      // a frozen clock enable must stretch the self-timed wait past its length
      repeat (2) @(negedge core_clk);
      clkEn = 1'b0;
      repeat (30 + ($urandom % 16)) @(negedge core_clk);
      samples_checked = samples_checked + 1;
      if (opPending !== 1'b1)
      begin
         $display("[FAIL] opPending under frozen enable expected 1 seen %b", opPending);
         n_errors = n_errors + 1;
      end
      clkEn = 1'b1;
      waitIdle();
      rdE(ea, ~d0);
      // page mode touches only the two loaded neighbours
      ld(8'hc1, ea[5:0] ^ 6'h01, d1);
      ld(8'hc1, ea[5:0] ^ 6'h02, d2);
      xfer({8'hc2, 6'h00, ea[9:6], 14'h0000}, 8'h00, 1'b0);
      waitIdle();
      rdE(ea ^ 10'h001, d1);
      rdE(ea ^ 10'h002, d2);
      rdE(ea, ~d0);
      // flash page of two words, low byte before high byte
      ld(8'h40, fa[5:0], d0);
      ld(8'h48, fa[5:0], d1);
      ld(8'h40, fa[5:0] ^ 6'h01, d2);
      ld(8'h48, fa[5:0] ^ 6'h01, d3);
      xfer({8'h4c, 3'h0, fa[12:6], 14'h0000}, 8'h00, 1'b0);
      waitIdle();
      rdF(1'b0, fa, d0);
      rdF(1'b1, fa, d1);
      rdF(1'b0, fa ^ 13'h0001, d2);
      rdF(1'b1, fa ^ 13'h0001, d3);
      rdF(1'b0, fa ^ 13'h0040, 8'hff);
      i_isp_programmer.session(1'b0);
      summarize();
   end
endmodule

/* File: verilog/isp_defs.vh */
// constants for the serial memory programming port
// assumes a 100 MHz core clock; included by bare name, definitions only
//
// What this block does
// - programming only while reset pin is low
// - refuse writes until programming enable seen
// - eeprom writes self-erase the target byte
// - chip erase fills both arrays with 0xff
// - sample input bits on clock rising edge
// - shift output bits on clock falling edge
// - echo enable second byte during third byte
// - flash page buffer loaded with six bits
// - flash page committed by seven upper bits
// - eeprom byte write, 3.6ms between bytes
// - eeprom page mode changes only loaded bytes
// - read instruction shifts out addressed byte
// - poll byte bit zero shows pending operation
// - decode enable and chip erase words
// - first byte selects flash load or write
// - first byte selects eeprom operation
`ifndef ISP_DEFS_VH
`define ISP_DEFS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define FLASH_PAGE_WAIT_US 2600
`define EEPROM_WRITE_WAIT_US 3600
`define CHIP_ERASE_WAIT_US 10500
`define FUSE_WRITE_WAIT_US 4500

// ----------------------------------------
// geometry
// ----------------------------------------
`define FLASH_AW 13
`define EE_AW 10
`define PAGE_BITS 6
`define ERASED_BYTE 8'hff

// ----------------------------------------
// instruction bytes
// ----------------------------------------
`define OP_ENABLE 8'hac
`define B2_ENABLE 8'h53
`define B2_ERASE 8'h80
`define OP_POLL 8'hf0
`define OP_FLOAD_LO 8'h40
`define OP_FLOAD_HI 8'h48
`define OP_FWRITE 8'h4c
`define OP_FREAD_LO 8'h20
`define OP_FREAD_HI 8'h28
`define OP_EREAD 8'ha0
`define OP_EWRITE 8'hc0
`define OP_ELOAD 8'hc1
`define OP_EPAGE 8'hc2

`endif

/* File: verilog/isp_mem.v */
// single port byte store with registered read data
// assumes one clock; contents are not reset
`timescale 1ns/100ps
module isp_mem #(
   parameter AW = 8,
   parameter DW = 8
)(
   // clock
   input wire clk,
   input wire clkEn,
   // access
   input wire we,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg [DW-1:0] rdata
);

   reg [DW-1:0] store [0:(1<<AW)-1];

   // read before write: rdata shows the old value next cycle
   always @(posedge clk)
   begin
      if (clkEn)
      begin
         if (we)
            store[addr] <= wdata;
         rdata <= store[addr];
      end
   end

endmodule

/* File: verilog/serial_prog_port.v */
// serial programming port: four byte instructions on a three wire link
// assumes sclk, sdi and progResetN come from pins outside core_clk domain
`timescale 1ns/100ps
`include "isp_defs.vh"
module serial_prog_port #(
   parameter FLASH_AW = `FLASH_AW,
   parameter EE_AW = `EE_AW,
   parameter PAGE_BITS = `PAGE_BITS,
   parameter [20:0] FLASH_WAIT = `FLASH_PAGE_WAIT_US * `CLK_MHZ,
   parameter [20:0] EE_WAIT = `EEPROM_WRITE_WAIT_US * `CLK_MHZ,
   parameter [20:0] ERASE_WAIT = `CHIP_ERASE_WAIT_US * `CLK_MHZ
)(
   // clock and reset
   input wire core_clk,
   input wire resetn,
   input wire clkEn,
   // link pins
   input wire sclk,
   input wire sdi,
   input wire progResetN,
   output reg sdo,
   // status
   output reg progEnabled,
   output reg opPending
);

   localparam FB = FLASH_AW + 1;
   localparam PB = PAGE_BITS + 1;
   localparam ST_IDLE = 3'd0;
   localparam ST_ERASE = 3'd1;
   localparam ST_FCOPY = 3'd2;
   localparam ST_ECOPY = 3'd3;
   localparam ST_EBYTE = 3'd4;
   localparam ST_WAIT = 3'd5;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [2:0] stage1;
   reg [2:0] stage2;
   reg [2:0] stage3;
   reg [2:0] stable;
   reg sclkPrev;
   wire sclkS = stable[2];
   wire sdiS = stable[1];
   wire session = ~stable[0];
   wire rise = sclkS & ~sclkPrev;
   wire fall = ~sclkS & sclkPrev;

   // a change counts only when stages two and three agree
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1 <= 3'h1;
         stage2 <= 3'h1;
         stage3 <= 3'h1;
         stable <= 3'h1;
         sclkPrev <= 1'b0;
      end
      else if (clkEn)
      begin
         stage1 <= {sclk, sdi, progResetN};
         stage2 <= stage1;
         stage3 <= stage2;
         stable <= (stage2 & stage3) | (stable & (stage2 | stage3));
         sclkPrev <= sclkS;
      end
   end

   // ----------------------------------------
   // serial shifter
   // ----------------------------------------
   reg [4:0] bitCnt;
   reg [31:0] inWord;
   reg [31:0] cmdWord;
   reg execPulse;
   reg [7:0] outShift;
   reg [1:0] rdDelay;
   reg rdFromEe;
   reg [2:0] state;
   wire [31:0] nextWord = {inWord[30:0], sdiS};
   wire [7:0] flashRdata;
   wire [7:0] eeRdata;

   // rising edge takes a bit in, falling edge drives a bit out
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bitCnt <= 5'h00;
         inWord <= 32'h00000000;
         cmdWord <= 32'h00000000;
         execPulse <= 1'b0;
         outShift <= 8'h00;
         rdDelay <= 2'h0;
         rdFromEe <= 1'b0;
         sdo <= 1'b0;
      end
      else if (clkEn)
      begin
         execPulse <= 1'b0;
         rdDelay <= {rdDelay[0], 1'b0};
         if (!session)
         begin
            // reset pin high drops byte alignment
            bitCnt <= 5'h00;
            outShift <= 8'h00;
            rdDelay <= 2'h0;
            sdo <= 1'b0;
         end
         else
         begin
            if (rise)
            begin
               inWord <= nextWord;
               bitCnt <= bitCnt + 5'h01;
               if (bitCnt == 5'd31)
               begin
                  cmdWord <= nextWord;
                  execPulse <= 1'b1;
               end
               if (bitCnt[2:0] == 3'h7)
               begin
                  // default echo is the byte just received
                  outShift <= nextWord[7:0];
                  if (bitCnt == 5'd23)
                  begin
                     if (nextWord[23:16] == `OP_POLL)
                        outShift <= {7'h00, opPending};
                     else if (nextWord[23:16] == `OP_FREAD_LO || nextWord[23:16] == `OP_FREAD_HI
                              || nextWord[23:16] == `OP_EREAD)
                     begin
                        rdDelay <= 2'h1;
                        rdFromEe <= (nextWord[23:16] == `OP_EREAD);
                     end
                  end
               end
            end
            if (rdDelay[1])
               outShift <= rdFromEe ? eeRdata : flashRdata;
            else if (fall)
            begin
               sdo <= outShift[7];
               outShift <= {outShift[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------
   // instruction decode
   // ----------------------------------------
   wire [7:0] op = cmdWord[31:24];
   wire isEnable = (cmdWord == {`OP_ENABLE, `B2_ENABLE, 16'h0000});
   wire isErase = (cmdWord == {`OP_ENABLE, `B2_ERASE, 16'h0000});
   wire canWrite = execPulse & progEnabled & (state == ST_IDLE);
   wire fLoad = canWrite & (op == `OP_FLOAD_LO || op == `OP_FLOAD_HI);
   wire eLoad = canWrite & (op == `OP_ELOAD);

   // ----------------------------------------
   // commit engine
   // ----------------------------------------
   reg [FB-1:0] idx;
   reg phase;
   reg [20:0] timer;
   reg [FLASH_AW-PAGE_BITS-1:0] fPage;
   reg [EE_AW-PAGE_BITS-1:0] ePage;
   reg [EE_AW-1:0] eeByteAddr;
   reg [7:0] eeByteData;
   reg [(1<<PAGE_BITS)-1:0] eeMask;
   wire [7:0] fbufRdata;
   wire [7:0] ebufRdata;
   wire lastFlash = (idx == {FB{1'b1}});
   wire eeInRange = (idx[FB-1:EE_AW] == {(FB-EE_AW){1'b0}});

   // enable latch, engine sequencing and the self-timed wait
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         progEnabled <= 1'b0;
         opPending <= 1'b0;
         state <= ST_IDLE;
         idx <= {FB{1'b0}};
         phase <= 1'b0;
         timer <= 21'h000000;
         fPage <= {(FLASH_AW-PAGE_BITS){1'b0}};
         ePage <= {(EE_AW-PAGE_BITS){1'b0}};
         eeByteAddr <= {EE_AW{1'b0}};
         eeByteData <= 8'h00;
         eeMask <= {(1<<PAGE_BITS){1'b0}};
      end
      else if (clkEn)
      begin
         if (!session)
            progEnabled <= 1'b0;
         else if (execPulse & isEnable)
            progEnabled <= 1'b1;
         if (eLoad)
            eeMask[cmdWord[8+PAGE_BITS-1:8]] <= 1'b1;
         case (state)
            ST_IDLE:
            begin
               idx <= {FB{1'b0}};
               phase <= 1'b0;
               if (canWrite & isErase)
               begin
                  state <= ST_ERASE;
                  opPending <= 1'b1;
               end
               else if (canWrite & (op == `OP_FWRITE))
               begin
                  fPage <= cmdWord[FLASH_AW+7:8+PAGE_BITS];
                  state <= ST_FCOPY;
                  opPending <= 1'b1;
               end
               else if (canWrite & (op == `OP_EPAGE))
               begin
                  ePage <= cmdWord[EE_AW+7:8+PAGE_BITS];
                  state <= ST_ECOPY;
                  opPending <= 1'b1;
               end
               else if (canWrite & (op == `OP_EWRITE))
               begin
                  eeByteAddr <= cmdWord[EE_AW+7:8];
                  eeByteData <= cmdWord[7:0];
                  state <= ST_EBYTE;
                  opPending <= 1'b1;
               end
            end
            ST_ERASE:
            begin
               // one location per cycle over the larger array
               idx <= idx + {{(FB-1){1'b0}}, 1'b1};
               if (lastFlash)
               begin
                  timer <= ERASE_WAIT;
                  state <= ST_WAIT;
               end
            end
            ST_FCOPY:
            begin
               // phase 0 reads the buffer, phase 1 writes the array
               phase <= ~phase;
               if (phase)
               begin
                  idx <= idx + {{(FB-1){1'b0}}, 1'b1};
                  if (idx[PB-1:0] == {PB{1'b1}})
                  begin
                     timer <= FLASH_WAIT;
                     state <= ST_WAIT;
                  end
               end
            end
            ST_ECOPY:
            begin
               phase <= ~phase;
               if (phase)
               begin
                  eeMask[idx[PAGE_BITS-1:0]] <= 1'b0;
                  idx <= idx + {{(FB-1){1'b0}}, 1'b1};
                  if (idx[PAGE_BITS-1:0] == {PAGE_BITS{1'b1}})
                  begin
                     timer <= EE_WAIT;
                     state <= ST_WAIT;
                  end
               end
            end
            ST_EBYTE:
            begin
               timer <= EE_WAIT;
               state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               // busy lasts the whole programming time
               if (timer <= 21'h000001)
               begin
                  opPending <= 1'b0;
                  state <= ST_IDLE;
               end
               else
                  timer <= timer - 21'h000001;
            end
            default:
            begin
               state <= ST_IDLE;
               opPending <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // memory ports
   // ----------------------------------------
   wire busyEng = (state != ST_IDLE);
   wire erasing = (state == ST_ERASE);
   // read address comes from the three registered bytes of the instruction
   wire [FB-1:0] rdFlashAddr = {inWord[FLASH_AW-1:0], inWord[19]};
   wire [FB-1:0] flashAddr = erasing ? idx : (busyEng ? {fPage, idx[PB-1:0]} : rdFlashAddr);
   wire flashWe = erasing | ((state == ST_FCOPY) & phase);
   wire [7:0] flashWdata = erasing ? `ERASED_BYTE : fbufRdata;

   wire [EE_AW-1:0] eeAddr = erasing ? idx[EE_AW-1:0] :
                             (state == ST_EBYTE) ? eeByteAddr :
                             busyEng ? {ePage, idx[PAGE_BITS-1:0]} : inWord[EE_AW-1:0];
   // page commit touches only bytes marked as loaded
   wire eeWe = (erasing & eeInRange) | (state == ST_EBYTE)
               | ((state == ST_ECOPY) & phase & eeMask[idx[PAGE_BITS-1:0]]);
   wire [7:0] eeWdata = erasing ? `ERASED_BYTE : ((state == ST_EBYTE) ? eeByteData : ebufRdata);

   // page buffers: word address in byte three, high byte select from opcode bit 3
   wire [PB-1:0] fbufAddr = busyEng ? idx[PB-1:0] : {cmdWord[8+PAGE_BITS-1:8], cmdWord[27]};
   wire [PAGE_BITS-1:0] ebufAddr = busyEng ? idx[PAGE_BITS-1:0] : cmdWord[8+PAGE_BITS-1:8];

   isp_mem #(.AW(FB)) flashArray (
      .clk(core_clk), .clkEn(clkEn), .we(flashWe),
      .addr(flashAddr), .wdata(flashWdata), .rdata(flashRdata)
   );

   isp_mem #(.AW(PB)) flashBuffer (
      .clk(core_clk), .clkEn(clkEn), .we(fLoad),
      .addr(fbufAddr), .wdata(cmdWord[7:0]), .rdata(fbufRdata)
   );

   isp_mem #(.AW(EE_AW)) eeArray (
      .clk(core_clk), .clkEn(clkEn), .we(eeWe),
      .addr(eeAddr), .wdata(eeWdata), .rdata(eeRdata)
   );

   isp_mem #(.AW(PAGE_BITS)) eeBuffer (
      .clk(core_clk), .clkEn(clkEn), .we(eLoad),
      .addr(ebufAddr), .wdata(cmdWord[7:0]), .rdata(ebufRdata)
   );

endmodule
